// File: conv_ctrl_params.svh
`ifndef CONV_CTRL_PARAMS_SVH
`define CONV_CTRL_PARAMS_SVH

// clock
`define CLK_PERIOD_NS     100
// initialization phase times, least times rounded up to whole cycles
`define T_REF_START_NS    5000
`define T_STRAP_SETTLE_NS 2000
`define T_NVM_LOAD_NS     4000
`define T_EN_DELAY_NS     10000
`define CYC_UP(t)         (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REF_START_CYC     8'(`CYC_UP(`T_REF_START_NS))
`define STRAP_SETTLE_CYC  8'(`CYC_UP(`T_STRAP_SETTLE_NS))
`define NVM_LOAD_CYC      8'(`CYC_UP(`T_NVM_LOAD_NS))
`define EN_DELAY_CYC      8'(`CYC_UP(`T_EN_DELAY_NS))
// soft-start durations in microseconds and their cycle counts
`define SS_T0_US          500
`define SS_T1_US          770
`define SS_T2_US          1000
`define SS_T3_US          2000
`define US_TO_CYC(t)      ((t) * 1000 / `CLK_PERIOD_NS)
// register byte offsets
`define OFS_CFG1          8'h00
`define OFS_CFG2          8'h04
`define OFS_CFG3          8'h08
`define OFS_SETPT         8'h0C
`define OFS_STATUS        8'h10
`define OFS_LEVEL         8'h14
// reset values
`define SPAN_RST          2'h2
`define SSDUR_RST         2'h2
`define SETPT_RST         8'h50
// setpoint arithmetic in units of 1.25 mV: 0.4 V base is 320 units
`define BASE_UNITS        11'h140
`define MULT_1P25         11'h001
`define MULT_2P5          11'h002
`define MULT_5P0          11'h004

`endif

// File: conv_ctrl_pkg.sv
package conv_ctrl_pkg;

    // initialization sequence after supply rises
    typedef enum logic [2:0] {
        INIT_LOCK  = 3'b000,
        INIT_REF   = 3'b001,
        INIT_MSB   = 3'b010,
        INIT_LSB   = 3'b011,
        INIT_LOAD  = 3'b100,
        INIT_RUN   = 3'b101
    } init_state_t;

    // converter power-up sequence
    typedef enum logic [1:0] {
        CONV_OFF   = 2'b00,
        CONV_DELAY = 2'b01,
        CONV_RAMP  = 2'b10,
        CONV_ON    = 2'b11
    } conv_state_t;

    // switching frequency, strap code one-to-one
    typedef enum logic [1:0] {
        FREQ_2P25  = 2'b00,
        FREQ_1P5   = 2'b01,
        FREQ_3P0   = 2'b10,
        FREQ_2P5   = 2'b11
    } freq_sel_t;

    // latched ahb address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] offset;
        logic       mapped;
    } bus_req_t;

    // fault inputs grouped
    typedef struct packed {
        logic thermal;
        logic overvolt;
    } fault_t;

endpackage

// File: conv_ctrl.sv
// Our own choices: the AHB-Lite slave port and the address map.
`include "conv_ctrl_params.svh"
// Behaviour
// (R1) enable line held low until defaults loaded and straps sampled
// (R2) init order: pull enable, reference, straps, defaults, then bus and release
// (R3) thermal or overvoltage fault actively pulls enable low
// (R4) shared enable stops switching until every stack member is ready
// (R5) standalone bit stops fault pulldown; init pulldown always stays
// (R6) software keeps standalone bit cleared when device is stacked
// (R7) ready flag low releases pulldown; enable level then switches converter; code releases it when run goes high
// (R8) register access open from end of init regardless of enable
// (R9) enable low gives shutdown: power stage and control off
// (R10) registers usable with enable low; ramp starts short delay after rise
// (R11) two-bit duration field picks 500us, 770us, 1ms default, 2ms
// (R12) setpoint, span, duration writes during soft-start wait until ramp ends
// (R13) reference ramps from zero so prebiased output sees only upper part
// (R14) discontinuous and pulse-skipping allowed throughout the start-up ramp
// (R15) frequency strap decoded once at init into four frequencies
// (R16) upper strap bit sampled with both probe switches open
// (R17) lower bit: close switch a or b by upper bit, resample
// (R18) span 00 1.25mV, 01 2.5mV, 10 and 11 5mV; default 5mV
// (R19) target is 0.4V plus setpoint code times selected step
// (R20) new span takes effect only at next setpoint write
// (R21) settings written while enable low apply at next enable
// (R22) strap code maps one-to-one; upper bit 0 ground side
module conv_ctrl
    import conv_ctrl_pkg::*;
#(
    parameter int unsigned SS0_CYC = `US_TO_CYC(`SS_T0_US),
    parameter int unsigned SS1_CYC = `US_TO_CYC(`SS_T1_US),
    parameter int unsigned SS2_CYC = `US_TO_CYC(`SS_T2_US),
    parameter int unsigned SS3_CYC = `US_TO_CYC(`SS_T3_US)
) (
    // clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // ahb-lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // supply and faults
    input  wire logic                 supply_ok,
    input  wire conv_ctrl_pkg::fault_t faults,
    // open-drain enable line
    input  wire logic                 en_in,
    output logic                      en_out,
    output logic                      en_oe,
    // frequency strap detector
    input  wire logic                 frequency_strap_pin,
    output logic                      probe_switch_a,
    output logic                      probe_switch_b,
    // converter control
    output logic                      ref_enable,
    output logic                      ctrl_enable,
    output logic                      power_stage_on,
    output logic                      dcm_allowed,
    output logic                      ramp_active,
    output conv_ctrl_pkg::freq_sel_t  freq_sel,
    output logic      [10:0]          ref_level
);
    import conv_ctrl_pkg::*;
    init_state_t init_q;
    conv_state_t conv_q;
    bus_req_t    req_q;
    logic [7:0]  icnt_q;
    logic        msb_q;
    logic [1:0]  span_q, span_act_q, ssdur_q;
    logic        single_q;
    logic [7:0]  setpt_q;
    logic [10:0] lat_target_q;
    logic [15:0] lat_dur_q, rcnt_q, acc_q;
    logic        rd_wait_q;
    logic        run, fault_any, pull_d, wr_fire, go;
    logic [10:0] live_target;
    logic [16:0] acc_sum;
    // target in 1.25 mV units from code and span
    function automatic logic [10:0] target_of(input logic [7:0] code, input logic [1:0] span);
        logic [10:0] mult;
        mult = (span == 2'b00) ? `MULT_1P25 : ((span == 2'b01) ? `MULT_2P5 : `MULT_5P0);
        return `BASE_UNITS + 11'(code * mult); // [R19] [R18]
    endfunction
    // soft-start cycles from duration field
    function automatic logic [15:0] dur_of(input logic [1:0] sel);
        logic [15:0] d;
        case (sel)
            2'b00:   d = 16'(SS0_CYC);
            2'b01:   d = 16'(SS1_CYC);
            2'b10:   d = 16'(SS2_CYC);
            default: d = 16'(SS3_CYC);
        endcase
        return d; // [R11]
    endfunction
    assign run         = (init_q == INIT_RUN);
    assign fault_any   = faults.thermal | faults.overvolt;
    // init pulldown always; fault pulldown unless standalone
    assign pull_d      = !run || (fault_any && !single_q); // [R1] [R3] [R5] [R7]
    assign wr_fire     = req_q.valid && req_q.write && req_q.mapped && run; // [R8]
    assign live_target = target_of(setpt_q, span_act_q);
    // shared line: any member pulling holds everyone off
    assign go          = run && en_in && !pull_d; // [R4]
    assign acc_sum     = {1'b0, acc_q} + {6'h00, lat_target_q};
    ////////////////////////////////////////////////////////////////////
    // initialization sequence
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            init_q         <= INIT_LOCK;
            icnt_q         <= 8'h00;
            msb_q          <= 1'b0;
            freq_sel       <= FREQ_2P25;
            probe_switch_a <= 1'b0;
            probe_switch_b <= 1'b0;
            ref_enable     <= 1'b0;
        end else if (!supply_ok) begin // lockout restarts the whole sequence
            init_q         <= INIT_LOCK;
            icnt_q         <= 8'h00;
            probe_switch_a <= 1'b0;
            probe_switch_b <= 1'b0;
            ref_enable     <= 1'b0;
        end else begin
            icnt_q <= icnt_q + 8'h01;
            case (init_q)
                INIT_LOCK: begin
                    init_q     <= INIT_REF; // [R2]
                    icnt_q     <= 8'h00;
                    ref_enable <= 1'b1;
                end
                INIT_REF: begin
                    if (icnt_q == `REF_START_CYC - 8'h01) begin
                        init_q <= INIT_MSB; // [R16]
                        icnt_q <= 8'h00;
                    end
                end
                INIT_MSB: begin
                    if (icnt_q == `STRAP_SETTLE_CYC - 8'h01) begin
                        msb_q          <= frequency_strap_pin; // [R16]
                        probe_switch_a <= !frequency_strap_pin; // [R17]
                        probe_switch_b <= frequency_strap_pin;
                        init_q         <= INIT_LSB;
                        icnt_q         <= 8'h00;
                    end
                end
                INIT_LSB: begin
                    if (icnt_q == `STRAP_SETTLE_CYC - 8'h01) begin
                        freq_sel       <= freq_sel_t'({msb_q, frequency_strap_pin}); // [R17] [R22] [R15]
                        probe_switch_a <= 1'b0;
                        probe_switch_b <= 1'b0;
                        init_q         <= INIT_LOAD;
                        icnt_q         <= 8'h00;
                    end
                end
                INIT_LOAD: begin
                    if (icnt_q == `NVM_LOAD_CYC - 8'h01) begin
                        init_q <= INIT_RUN; // [R2]
                    end
                end
                default: icnt_q <= icnt_q;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////
    // enable line: only ever pulls low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_out <= 1'b0;
            en_oe  <= 1'b1;
        end else begin
            en_out <= 1'b0;
            en_oe  <= pull_d; // [R1] [R3] [R5] [R7]
        end
    end
    ////////////////////////////////////////////////////////////////////
    // ahb address capture; reads wait one cycle so a write just ahead shows
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_q     <= '0;
            rd_wait_q <= 1'b0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (hready && hsel && htrans[1]) begin
                req_q.valid  <= 1'b1;
                req_q.write  <= hwrite;
                req_q.offset <= haddr[7:0];
                req_q.mapped <= (haddr[31:8] == 24'h000000) && (haddr[7:0] <= `OFS_LEVEL)
                                && (haddr[1:0] == 2'b00);
                rd_wait_q    <= !hwrite;
                hreadyout    <= hwrite;
            end else if (hready) begin
                req_q.valid <= 1'b0;
            end else if (rd_wait_q) begin
                rd_wait_q   <= 1'b0;
                hreadyout   <= 1'b1;
                req_q.valid <= 1'b0;
            end
        end
    end
    // read data; all zero before init ends or for unmapped addresses
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (rd_wait_q) begin
            hrdata <= 32'h00000000;
            if (run && req_q.mapped) begin // [R8] [R10]
                if (req_q.offset == `OFS_CFG1) begin
                    hrdata <= {30'h0, span_q};
                end else if (req_q.offset == `OFS_CFG2) begin
                    hrdata <= {30'h0, ssdur_q};
                end else if (req_q.offset == `OFS_CFG3) begin
                    hrdata <= {31'h0, single_q};
                end else if (req_q.offset == `OFS_SETPT) begin
                    hrdata <= {24'h0, setpt_q};
                end else if (req_q.offset == `OFS_STATUS) begin
                    hrdata <= {26'h0, freq_sel, conv_q, en_oe, run};
                end else begin
                    hrdata <= {21'h0, ref_level};
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////
    // software registers, stored at any time after init
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            span_q     <= `SPAN_RST; // [R18]
            span_act_q <= `SPAN_RST;
            ssdur_q    <= `SSDUR_RST; // [R11]
            single_q   <= 1'b0;
            setpt_q    <= `SETPT_RST;
        end else if (wr_fire) begin // [R21]
            if (req_q.offset == `OFS_CFG1) begin
                span_q <= hwdata[1:0];
            end else if (req_q.offset == `OFS_CFG2) begin
                ssdur_q <= hwdata[1:0];
            end else if (req_q.offset == `OFS_CFG3) begin
                single_q <= hwdata[0];
            end else if (req_q.offset == `OFS_SETPT) begin
                setpt_q    <= hwdata[7:0];
                span_act_q <= span_q; // [R20]
            end
        end
    end
    ////////////////////////////////////////////////////////////////////
    // converter sequence: delay, soft-start ramp, then tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            conv_q       <= CONV_OFF;
            rcnt_q       <= 16'h0000;
            acc_q        <= 16'h0000;
            lat_target_q <= 11'h000;
            lat_dur_q    <= 16'h0000;
            ref_level    <= 11'h000;
        end else if (!go) begin
            conv_q    <= CONV_OFF; // [R9]
            rcnt_q    <= 16'h0000;
            acc_q     <= 16'h0000;
            ref_level <= 11'h000;
        end else begin
            rcnt_q <= rcnt_q + 16'h0001;
            case (conv_q)
                CONV_OFF: begin
                    conv_q <= CONV_DELAY;
                    rcnt_q <= 16'h0000;
                end
                CONV_DELAY: begin
                    if (rcnt_q == {8'h00, `EN_DELAY_CYC} - 16'h0001) begin
                        conv_q       <= CONV_RAMP; // [R10]
                        rcnt_q       <= 16'h0000;
                        acc_q        <= 16'h0000;
                        lat_target_q <= live_target; // [R12]
                        lat_dur_q    <= dur_of(ssdur_q); // [R11]
                        ref_level    <= 11'h000; // [R13]
                    end
                end
                CONV_RAMP: begin
                    // fractional stepping; exact only for targets up to the count
                    if (acc_sum >= {1'b0, lat_dur_q}) begin
                        acc_q     <= 16'(acc_sum - {1'b0, lat_dur_q});
                        ref_level <= ref_level + 11'h001; // [R13]
                    end else begin
                        acc_q <= acc_sum[15:0];
                    end
                    if (rcnt_q == lat_dur_q - 16'h0001) begin
                        conv_q    <= CONV_ON; // [R12]
                        ref_level <= lat_target_q;
                    end
                end
                default: begin
                    // after the ramp, move one unit per cycle to live target
                    if (ref_level < live_target) begin
                        ref_level <= ref_level + 11'h001;
                    end else if (ref_level > live_target) begin
                        ref_level <= ref_level - 11'h001;
                    end
                end
            endcase
        end
    end
    // power stage and mode outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_enable    <= 1'b0;
            power_stage_on <= 1'b0;
            ramp_active    <= 1'b0;
            dcm_allowed    <= 1'b0;
        end else begin
            ctrl_enable    <= go; // [R9]
            power_stage_on <= go && (conv_q == CONV_RAMP || conv_q == CONV_ON); // [R4] [R7]
            ramp_active    <= go && (conv_q == CONV_RAMP);
            dcm_allowed    <= go && (conv_q == CONV_RAMP); // [R14]
        end
    end
    ////////////////////////////////////////////////////////////////////
    // checks
    sequence s_hold_off;
        !ramp_active[*8];
    endsequence
    sequence s_ramp_start;
        (conv_q == CONV_DELAY) ##1 (conv_q == CONV_RAMP);
    endsequence
    property p_init_pull;
        @(posedge hclk) disable iff (!hresetn) !run |=> en_oe;
    endproperty
    a_init_pull: assert property (p_init_pull) else $error("enable released before init"); // [R1]
    property p_fault_pull;
        @(posedge hclk) disable iff (!hresetn) run && fault_any && !single_q |=> en_oe;
    endproperty
    a_fault_pull: assert property (p_fault_pull) else $error("fault did not pull enable"); // [R3]
    property p_single;
        @(posedge hclk) disable iff (!hresetn) run && single_q |=> !en_oe;
    endproperty
    a_single: assert property (p_single) else $error("standalone still pulls enable"); // [R5]
    property p_shutdown;
        @(posedge hclk) disable iff (!hresetn) !en_in |=> !power_stage_on && !ctrl_enable;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("power stage on with enable low"); // [R9]
    property p_delay;
        @(posedge hclk) disable iff (!hresetn) $rose(conv_q == CONV_DELAY) |-> s_hold_off;
    endproperty
    a_delay: assert property (p_delay) else $error("ramp began without delay"); // [R10]
    property p_dur;
        @(posedge hclk) disable iff (!hresetn) s_ramp_start |-> lat_dur_q == dur_of($past(ssdur_q));
    endproperty
    a_dur: assert property (p_dur) else $error("wrong soft-start duration"); // [R11]
    property p_freeze;
        @(posedge hclk) disable iff (!hresetn)
            (conv_q == CONV_RAMP) && $past(conv_q == CONV_RAMP) |-> $stable(lat_target_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("latched target moved in ramp"); // [R12]
    property p_span;
        @(posedge hclk) disable iff (!hresetn)
            $changed(span_act_q) |-> $past(wr_fire && req_q.offset == `OFS_SETPT);
    endproperty
    a_span: assert property (p_span) else $error("span applied without setpoint write"); // [R20]
    property p_dcm;
        @(posedge hclk) disable iff (!hresetn) s_ramp_start |=> dcm_allowed[*2];
    endproperty
    a_dcm: assert property (p_dcm) else $error("dcm not allowed in ramp"); // [R14]
endmodule

// File: stack_partner.sv
module stack_partner (
    // parties on the shared enable line
    input  wire logic       dut_pull,
    input  wire logic       ext_en,
    input  wire logic       peer_hold,
    output logic            en_line,
    // frequency strap network
    input  wire logic [1:0] strap_kind,
    input  wire logic       probe_a,
    input  wire logic       probe_b,
    output logic            strap_level
);
    timeunit 1ns;
    timeprecision 100ps;

    ////////////////////////////////////////////////////////////////////////////
    // pull-up wins only when no party sinks the line, so one slow peer holds all
    assign en_line = !(dut_pull || !ext_en || peer_hold);

    ////////////////////////////////////////////////////////////////////////////
    // kind 00 short gnd, 01 resistor gnd, 11 short supply, 10 resistor supply
    // a resistor strap follows whichever probe is closed, so a wrong probe misreads
    always_comb begin
        if (!probe_a && !probe_b) begin
            strap_level = strap_kind[1];
        end else if (strap_kind[1] == strap_kind[0]) begin
            strap_level = strap_kind[1];
        end else begin
            strap_level = probe_a;
        end
    end
endmodule

// File: testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import conv_ctrl_pkg::*;

    localparam int          SS[4]   = '{200, 300, 400, 800};
    localparam logic [1:0]  KIND[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    localparam freq_sel_t   FEXP[4] = '{FREQ_2P25, FREQ_1P5, FREQ_2P5, FREQ_3P0};
    localparam logic [7:0]  ROFS[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20};
    localparam logic [31:0] RRST[5] = '{32'h2, 32'h2, 32'h0, 32'h50, 32'h0};

    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'h0, strap_kind = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic        hreadyout, hresp, en_out, en_oe, en_in, frequency_strap_pin;
    logic        probe_switch_a, probe_switch_b, ref_enable, ctrl_enable;
    logic        power_stage_on, dcm_allowed, ramp_active, saw_a, saw_b;
    logic        supply_ok = 1'b0, ext_en = 1'b0, peer_hold = 1'b0;
    fault_t      faults = 2'h0;
    freq_sel_t   freq_sel;
    logic [10:0] ref_level, lvl;
    int          errors = 0, checks_done = 0, n;

    always #50 hclk = ~hclk;

    conv_ctrl #(.SS0_CYC(200), .SS1_CYC(300), .SS2_CYC(400), .SS3_CYC(800)) dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .supply_ok, .faults,
        .en_in, .en_out, .en_oe, .frequency_strap_pin, .probe_switch_a,
        .probe_switch_b, .ref_enable, .ctrl_enable, .power_stage_on,
        .dcm_allowed, .ramp_active, .freq_sel, .ref_level
    );

    stack_partner far_side (
        .dut_pull(en_oe), .ext_en, .peer_hold, .en_line(en_in), .strap_kind,
        .probe_a(probe_switch_a), .probe_b(probe_switch_b),
        .strap_level(frequency_strap_pin)
    );

    ////////////////////////////////////////////////////////////////////////////
    // reporting
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // target in 1.25 mV units: 0.4 V base plus code times step
    function automatic logic [10:0] tgt(input logic [1:0] s, input logic [7:0] c);
        return 11'h140 + 11'(c) * (s == 2'h0 ? 11'h1 : (s == 2'h1 ? 11'h2 : 11'h4));
    endfunction

    function automatic logic cond(input int sel);
        case (sel)
            0: return hreadyout;
            1: return !en_oe;
            2: return ramp_active;
            default: return !ramp_active;
        endcase
    endfunction

    // looks at mid-cycle levels, which are what the next rising edge samples
    task automatic wait_on(input int sel, input int lim);
        n = 0;
        @(negedge hclk);
        while (cond(sel) !== 1'b1) begin
            saw_a |= probe_switch_a;
            saw_b |= probe_switch_b;
            n++;
            if (n > lim) begin
                errors++;
                wrap_up();
            end
            @(negedge hclk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // single-word bus cycle; every change lands right after a rising edge
    task automatic bus(input logic wr, input logic [7:0] o, input logic [31:0] d,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, o};
        wait_on(0, 20);
        @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_on(0, 20);
        @(posedge hclk);
        rd = hrdata; // taken at the edge that samples hready high
        check(hresp, 32'h0);
    endtask

    task automatic wr(input logic [7:0] o, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, o, d, x);
    endtask

    task automatic rd_chk(input logic [7:0] o, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, o, 32'h0, x);
        check(x, e);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge hclk);
        check(en_oe, 32'h1);
        hresetn <= 1'b1;
        // one power-up per strap kind
        for (int i = 0; i < 4; i++) begin
            @(posedge hclk);
            strap_kind <= KIND[i];
            supply_ok <= 1'b0;
            @(posedge hclk);
            supply_ok <= 1'b1;
            rd_chk(8'h0C, 32'h0);
            saw_a = 1'b0;
            saw_b = 1'b0;
            wait_on(1, 400);
            check(n >= 120, 32'h1);
            check({saw_a, saw_b}, {~KIND[i][1], KIND[i][1]});
            check(freq_sel, FEXP[i]);
            check({ref_enable, en_out}, 32'h2);
            rd_chk(8'h10, {26'h0, FEXP[i], 4'h1});
        end
        for (int i = 0; i < 5; i++) rd_chk(ROFS[i], RRST[i]);
        // settings stored while disabled, then every ramp duration
        wr(8'h00, 32'h0);
        wr(8'h0C, 32'h10);
        for (int d = 0; d < 4; d++) begin
            wr(8'h04, 32'(d));
            @(posedge hclk);
            ext_en <= 1'b1;
            wait_on(2, 150);
            check(n >= 95, 32'h1);
            check({dcm_allowed, power_stage_on}, 32'h3);
            if (d == 3) wr(8'h0C, 32'h40);
            wait_on(3, 900);
            check(n + 8 >= SS[d] && n <= SS[d] + 2, 32'h1);
            // ramp_active falls one edge after the ramp ends, so for d == 3, whose setpoint moved, tracking took one step
            check(ref_level, tgt(2'h0, 8'h10) + 11'(d == 3));
            repeat (60) @(negedge hclk);
            check(ref_level, tgt(2'h0, d == 3 ? 8'h40 : 8'h10));
            @(posedge hclk);
            ext_en <= 1'b0;
            repeat (3) @(negedge hclk);
            check({power_stage_on, ctrl_enable, ref_level}, 32'h0);
        end
        @(posedge hclk);
        ext_en <= 1'b1;
        wait_on(2, 150);
        wait_on(3, 900);
        // span change waits for a setpoint write
        for (int s = 0; s < 4; s++) begin
            lvl = ref_level;
            wr(8'h00, 32'(s));
            repeat (20) @(negedge hclk);
            check(ref_level, lvl);
            wr(8'h0C, 32'hC8);
            repeat (500) @(negedge hclk);
            check(ref_level, tgt(2'(s), 8'hC8));
        end
        // each fault kind pulls the line and stops the stage
        for (int f = 1; f < 3; f++) begin
            @(posedge hclk);
            faults <= fault_t'(2'(f));
            repeat (3) @(negedge hclk);
            check({en_oe, power_stage_on}, 32'h2);
            @(posedge hclk);
            faults <= 2'h0;
            wait_on(1, 20);
        end
        wr(8'h08, 32'h1);
        @(posedge hclk);
        faults <= 2'h2;
        repeat (3) @(negedge hclk);
        check(en_oe, 32'h0);
        @(posedge hclk);
        faults <= 2'h0;
        wr(8'h08, 32'h0);
        // a peer still holding the line keeps this stage off
        @(posedge hclk);
        peer_hold <= 1'b1;
        repeat (3) @(negedge hclk);
        check(power_stage_on, 32'h0);
        rd_chk(8'h04, 32'h3);
        @(posedge hclk);
        peer_hold <= 1'b0;
        wrap_up();
    end
endmodule
